// ===== core/charger_event_flag_mask_logic.sv
// event capture, read-to-clear flags, charger masks and interrupt pulse
// assumes status levels arrive asynchronously and registers come from
// the serial port engine on the same clock as this block
module charger_event_flag_mask_logic #(
    parameter int unsigned PULSE_CYCLES = charger_evt_pkg::INT_PULSE_CYC
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      reg_reset,
    // register access
    input  wire charger_evt_pkg::reg_req_s reg_req,
    output logic [7:0]                     reg_rdata,
    // status levels, asynchronous
    input  wire charger_evt_pkg::status_s  status_in,
    // blocks for flags 2, 3 and fault flags, from masks held elsewhere
    input  wire logic [31:0]               aux_irq_block,
    // interrupt pin
    output logic                           interrupt_out_low
);

    localparam int SW = $bits(charger_evt_pkg::status_s);
    localparam int CW = $clog2(PULSE_CYCLES + 1);
    localparam int NUM_REGS = charger_evt_pkg::NUM_FLAG_REGS;

    logic [SW-1:0]           meta_q;
    logic [SW-1:0]           sync_q;
    logic [SW-1:0]           prev_q;
    logic [2:0]              arm_q;
    logic                    armed;
    charger_evt_pkg::status_s s;
    charger_evt_pkg::status_s r;
    charger_evt_pkg::status_s c;
    charger_evt_pkg::status_s f;
    logic [7:0]              set_v  [NUM_REGS];
    logic [7:0]              flag_q [NUM_REGS];
    logic [7:0]              blk_v  [NUM_REGS];
    logic [NUM_REGS-1:0]     rd_hit;
    logic [NUM_REGS-1:0]     new_g;
    logic [7:0]              mask0_q;
    logic [7:0]              mask1_q;
    logic                    irq_new;
    logic [CW-1:0]           cnt_q;
    logic [CW-1:0]           cnt_d;

    // two flops before any logic; multi-bit codes may flag a change twice
    // when bits skew, which only costs the host an extra read
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= status_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edges are ignored until prev holds a real sample, so a status
    // already high at reset release raises no false event
    always_ff @(posedge clk) begin
        if (rst) begin
            arm_q <= 3'h0;
        end else begin
            arm_q <= {arm_q[1:0], 1'b1};
        end
    end

    assign armed = arm_q[2];
    assign s     = charger_evt_pkg::status_s'(sync_q);
    assign r     = charger_evt_pkg::status_s'(sync_q & ~prev_q);
    assign c     = charger_evt_pkg::status_s'(sync_q ^ prev_q);
    assign f     = charger_evt_pkg::status_s'(~sync_q & prev_q);

    always_comb begin
        set_v[0] = {r.iin_fwd | r.iin_rev,
                    r.vin_fwd | r.vin_rev,
                    r.wd_expired,
                    r.weak_source,
                    c.power_good_state,
                    c.input_two_present,
                    c.input_one_present,
                    c.bus_present};
        set_v[1] = {|c.charge_state,
                    |c.optimizer_state,
                    1'b0,
                    |c.source_type,
                    1'b0,
                    r.thermal_reg,
                    c.battery_present,
                    c.charger_detect_done};
        set_v[2] = {1'b0,
                    f.dataline_busy,
                    r.adc_done & s.adc_one_shot,
                    c.min_system_reg,
                    r.fast_timer_exp,
                    r.trickle_timer_exp,
                    r.precharge_timer_exp,
                    r.topoff_timer_exp};
        set_v[3] = {3'h0,
                    r.battery_low_reverse,
                    c.ts_cold,
                    c.ts_cool,
                    c.ts_warm,
                    c.ts_hot};
        set_v[4] = {c.discharge_reg,
                    r.bus_ov,
                    r.battery_ov,
                    r.bus_oc,
                    r.discharge_oc,
                    r.converter_oc,
                    r.input_two_ov,
                    r.input_one_ov};
        set_v[5] = {r.system_short,
                    r.system_ov,
                    r.reverse_ov,
                    r.reverse_uv,
                    1'b0,
                    r.thermal_shutdown,
                    2'h0};
        for (int i = 0; i < NUM_REGS; i++) begin
            if (!armed) begin
                set_v[i] = 8'h00;
            end
        end
    end

    // charger masks steer the pin; the other groups are masked elsewhere
    always_comb begin
        blk_v[0] = mask0_q;
        blk_v[1] = mask1_q;
        blk_v[2] = aux_irq_block[31:24];
        blk_v[3] = aux_irq_block[23:16];
        blk_v[4] = aux_irq_block[15:8];
        blk_v[5] = aux_irq_block[7:0];
    end

    generate
        for (genvar g = 0; g < NUM_REGS; g++) begin : flag_regs
            assign rd_hit[g] = reg_req.rd &&
                (reg_req.addr == charger_evt_pkg::FLAGS0_ADDR + 8'(g));
            assign new_g[g]  = |(set_v[g] & ~flag_q[g] & ~blk_v[g]);

            // set wins over the read clear in the same cycle
            always_ff @(posedge clk) begin
                if (rst || reg_reset) begin
                    flag_q[g] <= charger_evt_pkg::FLAG_RESET;
                end else if (g == 2 && s.dataline_busy) begin
                    flag_q[g] <= (flag_q[g] & ~{rd_hit[g] ? 8'hff : 8'h00}
                                 | set_v[g])
                                 & ~(8'h01 << charger_evt_pkg::DL_DONE_BIT);
                end else begin
                    flag_q[g] <= (flag_q[g] & ~{8{rd_hit[g]}})
                                 | set_v[g];
                end
            end

            // a captured event stays until its own register is read or reg_reset, and dataline done also clears while busy
            flag_sticky_a: assert property (
                @(posedge clk) disable iff (rst)
                !rd_hit[g] && !reg_reset && !(g == 2 && s.dataline_busy)
                |=> (flag_q[g] & $past(flag_q[g])) == $past(flag_q[g]))
                else $error("flag cleared without a read");

            // an event is lost only to reg_reset, never against a read clear
            set_lands_a: assert property (
                @(posedge clk) disable iff (rst)
                !reg_reset
                |=> (flag_q[g] & $past(set_v[g])) == $past(set_v[g]))
                else $error("event did not reach its flag");

            // a flag only comes up through its own event
            no_stray_set_a: assert property (
                @(posedge clk) disable iff (rst)
                !reg_reset |=> (flag_q[g] & ~$past(flag_q[g])
                                & ~$past(set_v[g])) == 8'h00)
                else $error("flag set without an event");
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst || reg_reset) begin
            mask0_q <= charger_evt_pkg::MASK_RESET;
            mask1_q <= charger_evt_pkg::MASK_RESET;
        end else if (reg_req.wr) begin
            if (reg_req.addr == charger_evt_pkg::MASK0_ADDR) begin
                mask0_q <= reg_req.wdata & charger_evt_pkg::MASK0_VALID;
            end
            if (reg_req.addr == charger_evt_pkg::MASK1_ADDR) begin
                mask1_q <= reg_req.wdata & charger_evt_pkg::MASK1_VALID;
            end
        end
    end

    // read data returns the value captured before the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                charger_evt_pkg::FLAGS0_ADDR: reg_rdata <= flag_q[0];
                charger_evt_pkg::FLAGS1_ADDR: reg_rdata <= flag_q[1];
                charger_evt_pkg::FLAGS2_ADDR: reg_rdata <= flag_q[2];
                charger_evt_pkg::FLAGS3_ADDR: reg_rdata <= flag_q[3];
                charger_evt_pkg::FAULT0_ADDR: reg_rdata <= flag_q[4];
                charger_evt_pkg::FAULT1_ADDR: reg_rdata <= flag_q[5];
                charger_evt_pkg::MASK0_ADDR:  reg_rdata <= mask0_q;
                charger_evt_pkg::MASK1_ADDR:  reg_rdata <= mask1_q;
                default:                      reg_rdata <= 8'h00;
            endcase
        end
    end

    // a flag already set raises no second pulse until the host reads it
    assign irq_new = |new_g;

    // every new event restarts the full width, so a burst keeps the pin low
    // until one width after its last event; reg_reset lets a pulse run out
    always_comb begin
        cnt_d = cnt_q;
        if (irq_new) begin
            cnt_d = CW'(PULSE_CYCLES);
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q             <= '0;
            interrupt_out_low <= 1'b1;
        end else begin
            cnt_q             <= cnt_d;
            interrupt_out_low <= (cnt_d == '0);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    iin_rise_flag_a: assert property (
        armed && sync_q[SW-1] && !prev_q[SW-1] && !reg_reset
        |=> flag_q[0][charger_evt_pkg::IIN_BIT])
        else $error("input current rise did not set its flag");

    pg_change_flag_a: assert property (
        armed && c.power_good_state && !reg_reset
        |=> flag_q[0][charger_evt_pkg::PG_BIT])
        else $error("power good change did not set its flag");

    oneshot_only_a: assert property (
        !flag_q[2][charger_evt_pkg::ADC_DONE_BIT] && !s.adc_one_shot
        && !reg_reset
        |=> !flag_q[2][charger_evt_pkg::ADC_DONE_BIT])
        else $error("conversion flag set outside one-shot mode");

    dl_busy_clear_a: assert property (
        s.dataline_busy && !reg_reset
        |=> !flag_q[2][charger_evt_pkg::DL_DONE_BIT])
        else $error("dataline done flag set while busy");

    reserved_zero_a: assert property (
        (flag_q[1] & 8'h28) == 8'h00 && (flag_q[3] & 8'he0) == 8'h00
        && (flag_q[2] & 8'h80) == 8'h00
        && (flag_q[5] & 8'h0b) == 8'h00
        && (mask1_q & ~charger_evt_pkg::MASK1_VALID) == 8'h00)
        else $error("reserved bit reads nonzero");

    read_returns_a: assert property (
        reg_req.rd && reg_req.addr == charger_evt_pkg::FLAGS0_ADDR
        |=> reg_rdata == $past(flag_q[0]))
        else $error("flag read returned wrong value");

    read_clears_a: assert property (
        rd_hit[0] && set_v[0] == 8'h00 && !reg_reset
        |=> flag_q[0] == 8'h00)
        else $error("flag read did not clear");

    set_beats_clear_a: assert property (
        rd_hit[1] && set_v[1] != 8'h00 && !reg_reset
        |=> (flag_q[1] & $past(set_v[1])) == $past(set_v[1]))
        else $error("event lost against read clear");

    masked_quiet_a: assert property (
        !irq_new && cnt_q == '0 |=> interrupt_out_low)
        else $error("interrupt pulsed without unmasked event");

    pulse_start_a: assert property (
        irq_new |=> !interrupt_out_low [*2])
        else $error("interrupt pulse did not start");

    pulse_end_a: assert property (
        cnt_q == CW'(1) && !irq_new |=> interrupt_out_low)
        else $error("interrupt pulse has wrong length");

    // checked against the mask registers, not the block vector
    unmasked_pin_a: assert property (
        |(set_v[0] & ~flag_q[0] & ~mask0_q)
        || |(set_v[1] & ~flag_q[1] & ~mask1_q)
        |=> !interrupt_out_low)
        else $error("unmasked event did not pulse the pin");

    // reg_reset wins over any event or write in the same cycle at the flags and masks, but an unmasked event still starts a pulse
    reg_clear_a: assert property (
        reg_reset |=> mask0_q == 8'h00 && mask1_q == 8'h00
        && (flag_q[0] | flag_q[1] | flag_q[2] | flag_q[3]
            | flag_q[4] | flag_q[5]) == 8'h00)
        else $error("register reset left a flag or mask set");

    pulse_cover_c: cover property (irq_new ##1 !interrupt_out_low);
    read_clear_c:  cover property (rd_hit[0] && flag_q[0] != 8'h00);
    masked_evt_c:  cover property (set_v[0] != 8'h00 && mask0_q != 8'h00);
    fault_evt_c:   cover property (set_v[4] != 8'h00);
    set_read_c:    cover property (rd_hit[1] && set_v[1] != 8'h00);

endmodule

// ===== pkg/charger_evt_pkg.sv
// constants, register map and carriers for the charger event flag block
// assumes one 125 MHz clock and a serial port engine that decodes registers
package charger_evt_pkg;

    // register map, byte addresses of the serial management port
    localparam logic [7:0] FLAGS0_ADDR = 8'h22;
    localparam logic [7:0] FLAGS1_ADDR = 8'h23;
    localparam logic [7:0] FLAGS2_ADDR = 8'h24;
    localparam logic [7:0] FLAGS3_ADDR = 8'h25;
    localparam logic [7:0] FAULT0_ADDR = 8'h26;
    localparam logic [7:0] FAULT1_ADDR = 8'h27;
    localparam logic [7:0] MASK0_ADDR  = 8'h28;
    localparam logic [7:0] MASK1_ADDR  = 8'h29;
    localparam int         NUM_FLAG_REGS = 6;

    // reset values and implemented bits
    localparam logic [7:0] FLAG_RESET  = 8'h00;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    localparam logic [7:0] MASK0_VALID = 8'hff;
    localparam logic [7:0] MASK1_VALID = 8'hd7;

    // bit positions inside the registers
    localparam int DL_DONE_BIT  = 6;
    localparam int ADC_DONE_BIT = 5;
    localparam int PG_BIT       = 3;
    localparam int IIN_BIT      = 7;

    // interrupt pulse width
    localparam int CLK_MHZ       = 125;
    localparam int INT_PULSE_US  = 256;
    localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;

    // register request from the serial port engine
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // status levels from the analog and state blocks
    typedef struct packed {
        logic       iin_fwd;
        logic       iin_rev;
        logic       vin_fwd;
        logic       vin_rev;
        logic       wd_expired;
        logic       weak_source;
        logic       power_good_state;
        logic       input_two_present;
        logic       input_one_present;
        logic       bus_present;
        logic [2:0] charge_state;
        logic [1:0] optimizer_state;
        logic [3:0] source_type;
        logic       thermal_reg;
        logic       battery_present;
        logic       charger_detect_done;
        logic       dataline_busy;
        logic       adc_done;
        logic       adc_one_shot;
        logic       min_system_reg;
        logic       fast_timer_exp;
        logic       trickle_timer_exp;
        logic       precharge_timer_exp;
        logic       topoff_timer_exp;
        logic       battery_low_reverse;
        logic       ts_cold;
        logic       ts_cool;
        logic       ts_warm;
        logic       ts_hot;
        logic       discharge_reg;
        logic       bus_ov;
        logic       battery_ov;
        logic       bus_oc;
        logic       discharge_oc;
        logic       converter_oc;
        logic       input_two_ov;
        logic       input_one_ov;
        logic       system_short;
        logic       system_ov;
        logic       reverse_ov;
        logic       reverse_uv;
        logic       thermal_shutdown;
    } status_s;

endpackage

// ===== verif/charger_event_flag_mask_logic_test.sv
// bench for the charger event flag block, with a reference flag model
// assumes the host model in the same folder and the package in pkg/
module charger_event_flag_mask_logic_test;
    timeunit 1ns;
    timeprecision 1ps;

    // short pulse keeps the run small
    localparam int unsigned PULSE = 8;

    logic                      clk = 1'b0;
    logic                      rst;
    logic                      reg_reset;
    charger_evt_pkg::reg_req_s reg_req;
    logic [7:0]                reg_rdata;
    charger_evt_pkg::status_s  status_q;
    charger_evt_pkg::status_s  status_prev;
    charger_evt_pkg::status_s  flip;
    logic [31:0]               aux_q;
    logic                      interrupt_out_low;
    logic [63:0]               raw;
    logic [7:0]                mflags [6];
    logic [7:0]                got [6];
    logic [7:0]                rv;
    int                        n_mismatch = 0;
    int                        num_checks = 0;
    int                        low_cnt = 0;
    int                        start;
    int                        seed;

    always #4 clk = ~clk;

    // width of each low pulse is counted here, not in the scenarios
    always @(posedge clk) begin
        if (interrupt_out_low === 1'b0) begin
            low_cnt <= low_cnt + 1;
        end
    end

    charger_event_flag_mask_logic #(
        .PULSE_CYCLES (PULSE)
    ) i_dut (
        .clk               (clk),
        .rst               (rst),
        .reg_reset         (reg_reset),
        .reg_req           (reg_req),
        .reg_rdata         (reg_rdata),
        .status_in         (status_q),
        .aux_irq_block     (aux_q),
        .interrupt_out_low (interrupt_out_low)
    );

    host_model i_host (
        .clk       (clk),
        .reg_req   (reg_req),
        .reg_rdata (reg_rdata)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] ev(input int k,
            input charger_evt_pkg::status_s o,
            input charger_evt_pkg::status_s n);
        charger_evt_pkg::status_s up;
        charger_evt_pkg::status_s ch;
        up = ~o & n;
        ch = o ^ n;
        case (k)
            0: return {up.iin_fwd | up.iin_rev, up.vin_fwd | up.vin_rev,
                       up.wd_expired, up.weak_source, ch.power_good_state,
                       ch.input_two_present, ch.input_one_present,
                       ch.bus_present};
            1: return {|ch.charge_state, |ch.optimizer_state, 1'b0,
                       |ch.source_type, 1'b0, up.thermal_reg,
                       ch.battery_present, ch.charger_detect_done};
            2: return {1'b0, o.dataline_busy & ~n.dataline_busy,
                       up.adc_done & n.adc_one_shot, ch.min_system_reg,
                       up.fast_timer_exp, up.trickle_timer_exp,
                       up.precharge_timer_exp, up.topoff_timer_exp};
            3: return {3'h0, up.battery_low_reverse, ch.ts_cold, ch.ts_cool,
                       ch.ts_warm, ch.ts_hot};
            4: return {ch.discharge_reg, up.bus_ov, up.battery_ov, up.bus_oc,
                       up.discharge_oc, up.converter_oc, up.input_two_ov,
                       up.input_one_ov};
            default: return {up.system_short, up.system_ov, up.reverse_ov,
                             up.reverse_uv, 1'b0, up.thermal_shutdown, 2'h0};
        endcase
    endfunction

    task automatic apply_status(input charger_evt_pkg::status_s n);
        @(posedge clk);
        status_q <= n;
        for (int k = 0; k < 6; k++) begin
            mflags[k] = mflags[k] | ev(k, status_prev, n);
        end
        if (n.dataline_busy) begin
            mflags[2][6] = 1'b0;
        end
        status_prev = n;
        repeat (8) @(posedge clk);
    endtask

    // a read returns the captured flags and clears them
    task automatic compare_all();
        i_host.read_flags(got);
        for (int k = 0; k < 6; k++) begin
            check(got[k], mflags[k]);
            mflags[k] = 8'h00;
        end
    endtask

    task automatic pulse_case(input logic [7:0] m0, input logic [7:0] m1,
            input logic [31:0] aux, input charger_evt_pkg::status_s f,
            input int exp_low);
        i_host.write_reg(charger_evt_pkg::MASK0_ADDR, m0);
        i_host.write_reg(charger_evt_pkg::MASK1_ADDR, m1);
        aux_q <= aux;
        compare_all();
        start = low_cnt;
        apply_status(status_prev ^ f);
        repeat (20) @(posedge clk);
        check(8'(low_cnt - start), 8'(exp_low));
        check({7'h0, interrupt_out_low}, 8'h01);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end

    initial begin
        seed = 32'h7bc8c8d6;
        rst = 1'b1;
        reg_reset = 1'b0;
        aux_q = '0;
        raw = {$random(seed), $random(seed)};
        status_q = raw[$bits(status_q)-1:0];
        status_prev = status_q;
        for (int k = 0; k < 6; k++) begin
            mflags[k] = 8'h00;
        end
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        // levels already high at release raise nothing
        for (int a = 8'h22; a <= 8'h2a; a++) begin
            i_host.read_reg(8'(a), rv);
            check(rv, 8'h00);
        end
        $display("test reset_values done");

        i_host.write_reg(charger_evt_pkg::MASK0_ADDR, 8'hff);
        i_host.write_reg(charger_evt_pkg::MASK1_ADDR, 8'hff);
        i_host.write_reg(charger_evt_pkg::FLAGS0_ADDR, 8'h5a);
        i_host.read_reg(charger_evt_pkg::MASK0_ADDR, rv);
        check(rv, 8'hff);
        i_host.read_reg(charger_evt_pkg::MASK1_ADDR, rv);
        check(rv, 8'hd7);
        i_host.read_reg(charger_evt_pkg::FLAGS0_ADDR, rv);
        check(rv, 8'h00);
        $display("test mask_access done");

        // every event masked: the pin must never move
        aux_q <= 32'hffffffff;
        start = low_cnt;
        for (int i = 0; i < 40; i++) begin
            raw = {$random(seed), $random(seed)};
            apply_status(raw[$bits(status_q)-1:0]);
            compare_all();
        end
        check(8'(low_cnt - start), 8'h00);
        $display("test random_events done");

        flip = '0;
        flip.bus_present = 1'b1;
        pulse_case(8'h00, 8'h00, 32'h0, flip, PULSE);
        pulse_case(8'h01, 8'h00, 32'h0, flip, 0);
        pulse_case(8'hfe, 8'hff, 32'hffffffff, flip, PULSE);
        flip = '0;
        flip.source_type = 4'h1;
        pulse_case(8'h00, 8'h10, 32'h0, flip, 0);
        pulse_case(8'hff, 8'hef, 32'hffffffff, flip, PULSE);
        flip = '0;
        flip.ts_hot = 1'b1;
        pulse_case(8'hff, 8'hff, 32'h00010000, flip, 0);
        pulse_case(8'hff, 8'hff, 32'hfffeffff, flip, PULSE);
        $display("test interrupt_pulse done");

        // an event landing on the clearing read edge survives that read
        compare_all();
        flip = '0;
        flip.charge_state = 3'h1;
        @(posedge clk);
        status_q <= status_prev ^ flip;
        status_prev = status_prev ^ flip;
        @(posedge clk);
        i_host.read_reg(charger_evt_pkg::FLAGS1_ADDR, rv);
        check(rv, 8'h00);
        i_host.read_reg(charger_evt_pkg::FLAGS1_ADDR, rv);
        check(rv, 8'h80);
        $display("test read_race done");

        flip = '0;
        flip.bus_present = 1'b1;
        apply_status(status_prev ^ flip);
        @(posedge clk);
        reg_reset <= 1'b1;
        @(posedge clk);
        reg_reset <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            mflags[k] = 8'h00;
        end
        i_host.read_reg(charger_evt_pkg::MASK0_ADDR, rv);
        check(rv, 8'h00);
        i_host.read_reg(charger_evt_pkg::MASK1_ADDR, rv);
        check(rv, 8'h00);
        compare_all();
        $display("test register_reset done");
        finish_test();
    end
endmodule

// ===== verif/host_model.sv
// host side model: register reads and writes, one strobe at a time
// assumes the block takes a strobe at an edge and answers one edge later
module host_model (
    // clock
    input  wire logic                 clk,
    // register port
    output charger_evt_pkg::reg_req_s reg_req,
    input  wire logic [7:0]           reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_req = '0;
    end

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_req.wr    <= 1'b1;
        reg_req.addr  <= addr;
        reg_req.wdata <= data;
        @(posedge clk);
        reg_req.wr    <= 1'b0;
        // released data must not look like the last value
        reg_req.wdata <= ~data;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        reg_req.rd   <= 1'b1;
        reg_req.addr <= addr;
        @(posedge clk);
        reg_req.rd   <= 1'b0;
        @(posedge clk);
        data = reg_rdata;
    endtask

    // every flag register is read before any status is looked at
    task automatic read_flags(output logic [7:0] data [6]);
        for (int k = 0; k < 6; k++) begin
            read_reg(charger_evt_pkg::FLAGS0_ADDR + 8'(k), data[k]);
        end
    endtask
endmodule
